// ---- common/sss_pkg.sv ----
// Constants shared by the select-synchronised serial port
package sss_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int SYNC_W = 3;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_DATA     = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL1    = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CTRL3    = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_STAT     = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h5;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL1_WRITE_COLLISION = 7;
    localparam int CTRL1_OV   = 6;
    localparam int CTRL1_EN   = 5;
    localparam int CTRL1_CKP  = 4;
    localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
    localparam int STAT_SMP   = 7;
    localparam int STAT_CKE   = 6;
    localparam int STAT_BF    = 0;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_WRITE_COLLISION   = 1;
    localparam int IRQ_OV     = 2;
    localparam int IRQ_W      = 3;
    localparam int SYNC_SEL   = 2;
    localparam int SYNC_SCK   = 1;
    localparam int SYNC_SIN   = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]        CTRL1_RST = 8'h00;
    localparam logic [7:0]        DATA_RST  = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RST   = 3'h0;
    localparam logic [SYNC_W-1:0] SYNC_RST  = 3'h4;

    // ---------------------------------------------------------------
    // Mode field codes
    // ---------------------------------------------------------------
    localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
    localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MST_ALT   = 4'h3;
    localparam logic [3:0] MODE_SLV_SEL   = 4'h4;
    localparam logic [3:0] MODE_SLV_FREE  = 4'h5;

    // ---------------------------------------------------------------
    // Timing counts (system clocks per half serial clock, minus one) and bits per byte
    // ---------------------------------------------------------------
    localparam logic [5:0] HALF_DIV4  = 6'h01;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV64 = 6'h1f;
    localparam logic [3:0] BITS_BYTE  = 4'h8;

endpackage

// ---- hdl/sss_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sss_sync (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      clock_en,
    input  wire logic [sss_pkg::SYNC_W-1:0] async_in,
    output logic      [sss_pkg::SYNC_W-1:0] level_out
);
    import sss_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] lvl;
    } sss_sync_t;

    sss_sync_t         st_reg;
    sss_sync_t         st_next;
    logic [SYNC_W-1:0] lvl_next;

    // ---------------------------------------------------------------
    // Agreement filter, one per input
    // ---------------------------------------------------------------
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        // Accept a change only once stages two and three agree
        assign lvl_next[i] = (st_reg.s2[i] == st_reg.s3[i]) ?
                             st_reg.s3[i] : st_reg.lvl[i];
    end

    // Next state
    always_comb begin
        st_next     = st_reg;
        st_next.s1  = async_in;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        st_next.lvl = lvl_next;
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= {SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST};
        end else if (clock_en) begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.lvl;

endmodule

// ---- hdl/sss_port.sv ----
// Byte-wide serial port with select synchronisation and sleep behaviour
// Summary of operation
// - Select-controlled slave mode runs only with mode field equal to 0100.
// - Select low enables shifting both ways and drives the data output.
// - Select high releases the data output once it has passed the synchroniser, even mid-byte.
// - Select high in that mode, or enable cleared, forces bit count to 0.
// - After deselection, counting restarts from the next select fall.
// - Master transfer holds its state in sleep and resumes on wake.
// - Slave shift register runs from the serial clock, also in sleep.
// - Slave byte of 8 bits sets the flag and requests wake if enabled.
// - Shifting is MSB first; a buffer write loads the shifter directly.
// - Completed byte goes to the buffer unless it is still full with overwrite off, setting buffer-full and flag.
// - Buffer write mid-byte is dropped and sets write collision.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sss_port (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      clock_en,
    input  wire logic                      sleep_mode,
    input  wire logic [sss_pkg::ADDR_W-1:0] addr,
    input  wire logic [sss_pkg::DATA_W-1:0] wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [sss_pkg::DATA_W-1:0] rdata,
    input  wire logic                      target_select_n,
    input  wire logic                      serial_in,
    input  wire logic                      serial_clock_pin_in,
    output logic                           serial_clock_pin_out,
    output logic                           serial_clock_pin_oe_n,
    output logic                           serial_out,
    output logic                           serial_out_oe_n,
    output logic                           port_irq_flag,
    output logic                           irq,
    output logic                           wake_request
);
    import sss_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       control_one;
        logic             buffer_overwrite_enable;
        logic             input_sample_phase;
        logic             transmit_edge;
        logic             rx_buffer_full;
        logic [7:0]       data_buffer;
        logic [7:0]       shift_register;
        logic [3:0]       bit_cnt;
        logic             mst_busy;
        logic [5:0]       div_cnt;
        logic             sck_out;
        logic             sck_oe_n;
        logic             sck_prev;
        logic             out_bit;
        logic             out_oe_n;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             irq;
        logic             wake;
        logic [7:0]       rdata;
    } sss_state_t;

    sss_state_t        st_reg;
    sss_state_t        st_next;
    logic [SYNC_W-1:0] pins_sync;

    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------
    sss_sync sss_sync_inst (
        .clock     (clock),
        .rst       (rst),
        .clock_en  (clock_en),
        .async_in  ({target_select_n, serial_clock_pin_in, serial_in}),
        .level_out (pins_sync)
    );

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic [3:0]       mode;
        logic             enabled;
        logic             clock_idle_level;
        logic             is_master;
        logic             is_slave;
        logic             sel_ok;
        logic             sel_high;
        logic             lead_edge;
        logic             trail_edge;
        logic             sample_edge;
        logic             launch_edge;
        logic             xfer_busy;
        logic             byte_done;
        logic [7:0]       new_byte;
        logic [5:0]       half_cnt;
        logic [IRQ_W-1:0] events;

        mode        = st_reg.control_one[3:0];
        enabled     = st_reg.control_one[CTRL1_EN];
        clock_idle_level         = st_reg.control_one[CTRL1_CKP];
        is_master   = enabled && (mode[3:2] == 2'b00);
        is_slave    = enabled &&
                      (mode == MODE_SLV_SEL || mode == MODE_SLV_FREE);
        sel_high    = pins_sync[SYNC_SEL];
        lead_edge   = 1'b0;
        trail_edge  = 1'b0;
        byte_done   = 1'b0;
        events      = '0;
        new_byte    = {st_reg.shift_register[6:0], pins_sync[SYNC_SIN]};
        st_next     = st_reg;
        st_next.rdata = 8'h00;

        // select pin honoured only in mode 0100
        sel_ok = is_slave && !(mode == MODE_SLV_SEL && sel_high);

        // Half-period of the generated serial clock
        unique case (mode)
            MODE_MST_DIV4:  half_cnt = HALF_DIV4;
            MODE_MST_DIV16: half_cnt = HALF_DIV16;
            default:        half_cnt = HALF_DIV64;
        endcase

        // Transfer in progress, used for collision detection
        xfer_busy = (is_master && st_reg.mst_busy) ||
                    (is_slave && st_reg.bit_cnt != 4'h0);

        // -----------------------------------------------------------
        // Slave edges from the sampled serial clock
        // -----------------------------------------------------------
        st_next.sck_prev = pins_sync[SYNC_SCK];
        // slave shifts on serial clock edges, sleep or not
        if (sel_ok) begin
            lead_edge  = (pins_sync[SYNC_SCK] != clock_idle_level) &&
                         (st_reg.sck_prev == clock_idle_level);
            trail_edge = (pins_sync[SYNC_SCK] == clock_idle_level) &&
                         (st_reg.sck_prev != clock_idle_level);
        end

        // -----------------------------------------------------------
        // Master clock generator
        // -----------------------------------------------------------
        if (!is_master || !st_reg.mst_busy) begin
            st_next.sck_out = clock_idle_level;
            st_next.div_cnt = 6'h00;
        // sleep freezes the master transfer in place
        end else if (!sleep_mode) begin
            if (st_reg.div_cnt == half_cnt) begin
                st_next.div_cnt = 6'h00;
                st_next.sck_out = !st_reg.sck_out;
                lead_edge       = (st_reg.sck_out == clock_idle_level);
                trail_edge      = (st_reg.sck_out != clock_idle_level);
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 6'h01;
            end
        end
        st_next.sck_oe_n = !is_master;

        // Transmit edge bit picks which edge samples
        sample_edge = st_reg.transmit_edge ? lead_edge : trail_edge;
        launch_edge = st_reg.transmit_edge ? trail_edge : lead_edge;

        // -----------------------------------------------------------
        // Shifting
        // -----------------------------------------------------------
        // shift in at the LSB, present the MSB
        if (launch_edge) begin
            st_next.out_bit = st_reg.shift_register[7];
        end
        if (sample_edge && st_reg.bit_cnt != BITS_BYTE) begin
            st_next.shift_register = new_byte;
            st_next.bit_cnt        = st_reg.bit_cnt + 4'h1;
            if (st_reg.bit_cnt == BITS_BYTE - 4'h1) begin
                byte_done = 1'b1;
                // Slave wraps for the next byte
                if (is_slave) begin
                    st_next.bit_cnt = 4'h0;
                end
            end
        end

        // Master stops once the clock is back at idle
        if (is_master && st_reg.mst_busy && trail_edge &&
            st_next.bit_cnt == BITS_BYTE) begin
            st_next.mst_busy = 1'b0;
            st_next.bit_cnt  = 4'h0;
        end

        // deselect or disable clears the bit counter
        if (!enabled || (is_slave && mode == MODE_SLV_SEL && sel_high)) begin
            // next select fall starts a fresh byte
            st_next.bit_cnt  = 4'h0;
            st_next.mst_busy = 1'b0;
        end

        // release data out the cycle after the synchronised select goes high
        // float modelled by an active-low enable
        st_next.out_oe_n = !(sel_ok || is_master);

        // -----------------------------------------------------------
        // Register writes
        // -----------------------------------------------------------
        if (wr_stb) begin
            unique case (addr)
                OFF_DATA: begin
                    // write during a byte is dropped
                    if (xfer_busy || st_reg.control_one[CTRL1_WRITE_COLLISION]) begin
                        events[IRQ_WRITE_COLLISION] = 1'b1;
                    end else begin
                        st_next.shift_register = wdata;
                        st_next.out_bit        = wdata[7];
                        if (is_master) begin
                            st_next.mst_busy = 1'b1;
                            st_next.bit_cnt  = 4'h0;
                        end
                    end
                end
                OFF_CTRL1: begin
                    // Flags clear by writing zero, config bits store
                    st_next.control_one = {
                        st_reg.control_one[CTRL1_WRITE_COLLISION] & wdata[CTRL1_WRITE_COLLISION],
                        st_reg.control_one[CTRL1_OV] & wdata[CTRL1_OV],
                        wdata[5:0]};
                end
                OFF_CTRL3: begin
                    st_next.buffer_overwrite_enable = wdata[CTRL3_BUFFER_OVERWRITE_ENABLE];
                end
                OFF_STAT: begin
                    st_next.input_sample_phase = wdata[STAT_SMP];
                    st_next.transmit_edge      = wdata[STAT_CKE];
                end
                OFF_IRQ_STAT: begin
                    // Write one to clear
                    st_next.irq_stat = st_reg.irq_stat & ~wdata[IRQ_W-1:0];
                end
                OFF_IRQ_MASK: begin
                    st_next.irq_mask = wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // -----------------------------------------------------------
        // Register reads, data in the following cycle
        // -----------------------------------------------------------
        if (rd_stb) begin
            unique case (addr)
                OFF_DATA: begin
                    st_next.rdata          = st_reg.data_buffer;
                    st_next.rx_buffer_full = 1'b0;
                end
                OFF_CTRL1:    st_next.rdata = st_reg.control_one;
                OFF_CTRL3:    st_next.rdata =
                    {3'h0, st_reg.buffer_overwrite_enable, 4'h0};
                OFF_STAT:     st_next.rdata =
                    {st_reg.input_sample_phase, st_reg.transmit_edge,
                     5'h00, st_reg.rx_buffer_full};
                OFF_IRQ_STAT: st_next.rdata = {5'h00, st_reg.irq_stat};
                OFF_IRQ_MASK: st_next.rdata = {5'h00, st_reg.irq_mask};
                default:      st_next.rdata = 8'h00;
            endcase
        end

        // -----------------------------------------------------------
        // Byte completion, after the bus so a set beats a clear
        // -----------------------------------------------------------
        if (byte_done) begin
            events[IRQ_DONE] = 1'b1;
            if (st_next.rx_buffer_full && !st_reg.buffer_overwrite_enable)
            begin
                // Unread byte kept, newer one lost
                events[IRQ_OV] = 1'b1;
            end else begin
                st_next.data_buffer    = new_byte;
                st_next.rx_buffer_full = 1'b1;
            end
        end

        // Sticky flags, hardware set wins
        if (events[IRQ_WRITE_COLLISION]) begin
            st_next.control_one[CTRL1_WRITE_COLLISION] = 1'b1;
        end
        if (events[IRQ_OV]) begin
            st_next.control_one[CTRL1_OV] = 1'b1;
        end
        st_next.irq_stat = st_next.irq_stat | events;

        // unmasked flag drives interrupt and wake request
        st_next.irq  = |(st_next.irq_stat & st_next.irq_mask);
        st_next.wake = st_next.irq && sleep_mode;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg                         <= '0;
            st_reg.control_one             <= CTRL1_RST;
            st_reg.data_buffer             <= DATA_RST;
            st_reg.shift_register          <= DATA_RST;
            st_reg.irq_stat                <= IRQ_RST;
            st_reg.irq_mask                <= IRQ_RST;
            st_reg.sck_oe_n                <= 1'b1;
            st_reg.out_oe_n                <= 1'b1;
            st_reg.sck_prev                <= 1'b0;
        end else if (clock_en) begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, each straight from the state register
    // ---------------------------------------------------------------
    assign rdata                 = st_reg.rdata;
    assign serial_clock_pin_out  = st_reg.sck_out;
    assign serial_clock_pin_oe_n = st_reg.sck_oe_n;
    assign serial_out            = st_reg.out_bit;
    assign serial_out_oe_n       = st_reg.out_oe_n;
    assign port_irq_flag         = st_reg.irq_stat[IRQ_DONE];
    assign irq                   = st_reg.irq;
    assign wake_request          = st_reg.wake;

endmodule

// ---- tb/sss_sva.sv ----
// Port-level checks for the serial port
`timescale 1ns/1ps
module sss_sva (
    input wire logic                       clock,
    input wire logic                       rst,
    input wire logic                       clock_en,
    input wire logic                       sleep_mode,
    input wire logic [sss_pkg::ADDR_W-1:0] addr,
    input wire logic [sss_pkg::DATA_W-1:0] wdata,
    input wire logic                       wr_stb,
    input wire logic                       rd_stb,
    input wire logic [sss_pkg::DATA_W-1:0] rdata,
    input wire logic                       target_select_n,
    input wire logic                       serial_in,
    input wire logic                       serial_clock_pin_in,
    input wire logic                       serial_clock_pin_out,
    input wire logic                       serial_clock_pin_oe_n,
    input wire logic                       serial_out,
    input wire logic                       serial_out_oe_n,
    input wire logic                       port_irq_flag,
    input wire logic                       irq,
    input wire logic                       wake_request
);
    import sss_pkg::*;
    logic [2:0] hi_cnt_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles with select held high, saturating
    always_ff @(posedge clock) begin
        if (rst || !target_select_n)
            hi_cnt_reg <= 3'h0;
        else if (hi_cnt_reg != 3'h7)
            hi_cnt_reg <= hi_cnt_reg + 3'h1;
    end
    a_sel_floats: assert property (
        hi_cnt_reg > 3'h6 && serial_clock_pin_oe_n |-> serial_out_oe_n)
        else $error("data out driven while deselected");
    a_release_bound: assert property (
        $rose(target_select_n) && serial_clock_pin_oe_n
        |-> ##[1:7] serial_out_oe_n) else $error("data out not released");
    a_rdata_idle: assert property (
        !$past(rd_stb) |-> rdata == 8'h00) else $error("read data not idle");
    a_reset_quiet: assert property (
        $past(rst) |-> serial_out_oe_n && serial_clock_pin_oe_n && !irq)
        else $error("outputs active after reset");
    a_sleep_clk_hold: assert property (
        sleep_mode && $past(sleep_mode) && !serial_clock_pin_oe_n
        |-> $stable(serial_clock_pin_out)) else $error("clock moved in sleep");
    a_sleep_data_hold: assert property (
        sleep_mode && $past(sleep_mode) && !serial_clock_pin_oe_n
        |-> $stable(serial_out)) else $error("data moved in sleep");
    a_wake_cause: assert property (
        wake_request |-> $past(sleep_mode)) else $error("wake without sleep");
    a_wake_raise: assert property (
        irq && sleep_mode && $past(irq && sleep_mode) |-> wake_request)
        else $error("no wake on interrupt");
endmodule
bind sss_port sss_sva sss_sva_inst (.*);

// ---- tb/sss_master_model.sv ----
// Serial bus master model driving select, clock and data
`timescale 1ns/1ps
module sss_master_model (
    output logic      target_select_n,
    output logic      serial_clock_pin_in,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    logic drv_bad;
    // Idle: deselected, clock at idle level
    initial begin
        target_select_n = 1'b1;
        serial_clock_pin_in = 1'b0;
        serial_in = 1'b0;
        drv_bad = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, input int nb,
                        output logic [7:0] rx);
        rx = 8'h00;
        #3; // Keep pin changes off the system clock edges
        target_select_n = 1'b0;
        #160;
        for (int i = 0; i < nb; i++) begin
            serial_clock_pin_in = 1'b1;
            serial_in = tx[7-i];
            #80;
            serial_clock_pin_in = 1'b0;
            rx = {rx[6:0], serial_out ^ serial_out_oe_n}; // Float reads inverted
            if (serial_out_oe_n !== 1'b0)
                drv_bad = 1'b1;
            #80;
        end
        #80;
        target_select_n = 1'b1;
        serial_in = ~serial_in; // Released line shows no stale bit
    endtask
endmodule

// ---- tb/test_spi_slave_select_sync.sv ----
// Self-checking bench for the select-synchronised serial port
`timescale 1ns/1ps
module test_spi_slave_select_sync;
    import sss_pkg::*;
    logic              clock, rst, sleep_mode, wr_stb, rd_stb, clk_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rx;
    logic              tsel_n, sck, sin, sout, sout_oe_n;
    logic              sck_out, sck_oe_n, flag, irq, wake;
    int                err_total, n_tests;
    sss_port sss_port_inst (
        .clock(clock), .rst(rst), .clock_en(clk_en),
        .sleep_mode(sleep_mode), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .target_select_n(tsel_n), .serial_in(sin),
        .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe_n(sck_oe_n), .serial_out(sout),
        .serial_out_oe_n(sout_oe_n), .port_irq_flag(flag),
        .irq(irq), .wake_request(wake));
    sss_master_model m_inst (
        .target_select_n(tsel_n), .serial_clock_pin_in(sck),
        .serial_in(sin), .serial_out(sout), .serial_out_oe_n(sout_oe_n));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic frame(input logic [7:0] tx, input int nb);
        m_inst.xfer(tx, nb, rx);
        repeat (10) @(posedge clock);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Watchdog against a hang
    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        sleep_mode = 1'b0;
        clk_en = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 7; a++)
            rd(a[2:0], 8'h00);
        chk({6'h0, sck_oe_n, sout_oe_n}, 8'h03);
        $display("test reset done");
        wr(OFF_IRQ_MASK, 8'h07);
        // select mode, edge and phase bits clear
        wr(OFF_CTRL1, 8'h24);
        wr(OFF_DATA, 8'ha5);
        frame(8'h3c, 8);
        chk(rx, 8'ha5);
        chk({7'h0, m_inst.drv_bad}, 8'h00);
        chk({6'h0, irq, flag}, 8'h03);
        rd(OFF_STAT, 8'h01);
        rd(OFF_DATA, 8'h3c);
        rd(OFF_STAT, 8'h00);
        wr(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("test byte done");
        wr(OFF_IRQ_MASK, 8'h00);
        frame(8'hff, 3);
        chk({7'h0, flag}, 8'h00);
        frame(8'hc3, 8);
        chk({6'h0, irq, flag}, 8'h01);
        rd(OFF_DATA, 8'hc3);
        wr(OFF_IRQ_STAT, 8'h01);
        $display("test abort done");
        fork
            frame(8'h11, 8);
            begin
                #600;
                wr(OFF_DATA, 8'h77);
            end
        join
        rd(OFF_CTRL1, 8'ha4);
        rd(OFF_IRQ_STAT, 8'h03);
        wr(OFF_CTRL1, 8'h24);
        wr(OFF_IRQ_STAT, 8'h03);
        rd(OFF_CTRL1, 8'h24);
        rd(OFF_DATA, 8'h11);
        $display("test collision done");
        wr(OFF_IRQ_MASK, 8'h01);
        sleep_mode <= 1'b1;
        frame(8'h96, 8);
        chk({5'h0, wake, irq, flag}, 8'h07);
        sleep_mode <= 1'b0;
        rd(OFF_DATA, 8'h96);
        wr(OFF_IRQ_STAT, 8'h01);
        $display("test sleep slave done");
        // leading-edge sampling keeps select control, phase clear
        wr(OFF_STAT, 8'h40);
        wr(OFF_DATA, 8'h5a);
        frame(8'he0, 8);
        chk(rx, 8'h5a);
        rd(OFF_STAT, 8'h41);
        rd(OFF_DATA, 8'he0);
        wr(OFF_STAT, 8'h00);
        wr(OFF_IRQ_STAT, 8'h01);
        $display("test leading edge done");
        wr(OFF_CTRL1, 8'h20);
        wr(OFF_DATA, 8'h81);
        repeat (6) @(posedge clock);
        sleep_mode <= 1'b1;
        repeat (40) @(posedge clock);
        chk({7'h0, flag}, 8'h00);
        sleep_mode <= 1'b0;
        clk_en <= 1'b0;
        repeat (20) @(posedge clock);
        chk({7'h0, flag}, 8'h00);
        clk_en <= 1'b1;
        repeat (60) @(posedge clock);
        chk({7'h0, flag}, 8'h01);
        chk({6'h0, sck_oe_n, sck_out}, 8'h00);
        rd(OFF_DATA, 8'hff);
        $display("test sleep master done");
        print_verdict;
    end
endmodule
